/* common/zdcps_pkg.sv */
// Package: register map, field positions and bus types for the zero-delay config block
package zdcps_pkg;
	// Printed offsets are not all multiples of four, so they are indices
	localparam logic [7:0] ZDCPS_IDX_ZD_CTRL = 8'h1e;
	localparam logic [7:0] ZDCPS_IDX_STATUS = 8'h1f;
	localparam logic [7:0] ZDCPS_IDX_EVT_STAT = 8'h20;
	localparam logic [7:0] ZDCPS_IDX_EVT_MASK = 8'h21;
	localparam logic [7:0] ZDCPS_IDX_READBACK_CTRL = 8'h22;
	localparam int ZDCPS_ADDR_W = 10;
	localparam logic [9:0] ZDCPS_ADDR_ZD_CTRL = {ZDCPS_IDX_ZD_CTRL, 2'b00};
	localparam logic [9:0] ZDCPS_ADDR_STATUS = {ZDCPS_IDX_STATUS, 2'b00};
	localparam logic [9:0] ZDCPS_ADDR_EVT_STAT = {ZDCPS_IDX_EVT_STAT, 2'b00};
	localparam logic [9:0] ZDCPS_ADDR_EVT_MASK = {ZDCPS_IDX_EVT_MASK, 2'b00};
	localparam logic [9:0] ZDCPS_ADDR_READBACK_CTRL = {ZDCPS_IDX_READBACK_CTRL, 2'b00};
	// Zero-delay control fields
	localparam int ZDCPS_FB_SEL_LSB = 3;
	localparam int ZDCPS_ZD_EXT_BIT = 2;
	localparam int ZDCPS_ZD_EN_BIT = 1;
	localparam logic [7:0] ZDCPS_ZD_CTRL_RST = 8'h00;
	localparam logic [7:0] ZDCPS_ZD_CTRL_MASK = 8'h1e;
	localparam logic [1:0] ZDCPS_FB_DIV0 = 2'h0;
	localparam logic [1:0] ZDCPS_FB_DIV1 = 2'h1;
	localparam logic [1:0] ZDCPS_FB_DIV2 = 2'h2;
	localparam logic [1:0] ZDCPS_FB_DIV3 = 2'h3;
	// Status bit positions
	localparam int ZDCPS_ST_CAL_DONE = 6;
	localparam int ZDCPS_ST_HOLDOVER = 5;
	localparam int ZDCPS_ST_SEC_REF = 4;
	localparam int ZDCPS_ST_VCO_ABOVE = 3;
	localparam int ZDCPS_ST_SEC_ABOVE = 2;
	localparam int ZDCPS_ST_FIRST_ABOVE = 1;
	localparam int ZDCPS_ST_LOCKED = 0;
	localparam logic [6:0] ZDCPS_STATUS_RST = 7'h00;
	localparam logic [6:0] ZDCPS_EVT_RST = 7'h00;
	localparam logic [1:0] ZDCPS_RESP_OKAY = 2'h0;
	localparam logic [1:0] ZDCPS_RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic cal_done;
		logic holdover_active;
		logic second_ref_sel;
		logic vco_above;
		logic second_ref_above;
		logic first_ref_above;
		logic locked;
	} zdcps_mon_t;

	typedef struct packed {
		logic zd_enable;
		logic zd_external;
		logic [1:0] fb_div_sel;
		logic [3:0] fb_div_onehot;
	} zdcps_zd_t;

	typedef enum logic [2:0] {
		ZDCPS_W_IDLE = 3'b001,
		ZDCPS_W_HAVE = 3'b010,
		ZDCPS_W_RESP = 3'b100
	} zdcps_wstate_t;

	typedef struct packed {
		zdcps_wstate_t wst;
		logic aw_got;
		logic w_got;
		logic [9:0] waddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [7:0] zd_ctrl;
		logic [6:0] status;
		logic readback_off;
		logic [6:0] evt_stat;
		logic [6:0] evt_mask;
		logic [6:0] mon_prev;
	} zdcps_state_t;
endpackage : zdcps_pkg

/* design/zdcps_regs.sv */
// Zero-delay configuration and PLL status register bank with AXI4-Lite slave
//
// Summary of operation
// - Two-bit select picks divider 0..3, reset 0
// - Mode bit: 0 internal, 1 external zero-delay
// - Enable bit turns zero-delay on, reset off
// - Status bit 6 shows calibration finished
// - Status bit 5 shows holdover actually active
// - Status bit 4 set when second reference selected
// - Status bit 3 shows VCO above threshold
// - Status bit 2 shows second reference above threshold
// - Status bit 1 shows first reference above threshold
// - Status bit 0 shows digital lock
// - Readback disable freezes status register updates
module zdcps_regs
	import zdcps_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [ZDCPS_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [ZDCPS_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	input wire zdcps_mon_t mon,
	output zdcps_zd_t zd_cfg,
	output logic irq
);

	zdcps_state_t s_r;
	zdcps_state_t s_nxt;
	logic aw_take;
	logic w_take;
	logic ar_take;
	logic [6:0] mon_vec;
	logic [6:0] evt_set;

	////////////////////////////////////////////////////////////////////////////////
	// Decode and read mux

	function automatic logic addr_known(input logic [9:0] a);
		return a == ZDCPS_ADDR_ZD_CTRL || a == ZDCPS_ADDR_STATUS || a == ZDCPS_ADDR_EVT_STAT ||
			a == ZDCPS_ADDR_EVT_MASK || a == ZDCPS_ADDR_READBACK_CTRL;
	endfunction

	function automatic logic [31:0] read_word(input zdcps_state_t st, input logic [9:0] a);
		logic [31:0] d;
		d = 32'h0000_0000;
		unique case (a)
			ZDCPS_ADDR_ZD_CTRL: d[7:0] = st.zd_ctrl;
			ZDCPS_ADDR_STATUS: d[6:0] = st.status;
			ZDCPS_ADDR_EVT_STAT: d[6:0] = st.evt_stat;
			ZDCPS_ADDR_EVT_MASK: d[6:0] = st.evt_mask;
			ZDCPS_ADDR_READBACK_CTRL: d[0] = st.readback_off;
			default: d = 32'h0000_0000;
		endcase
		return d;
	endfunction

	assign s_axi_awready = s_r.wst == ZDCPS_W_IDLE && !s_r.aw_got;
	assign s_axi_wready = s_r.wst == ZDCPS_W_IDLE && !s_r.w_got;
	assign s_axi_arready = !s_r.rvalid;
	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take = s_axi_wvalid && s_axi_wready;
	assign ar_take = s_axi_arvalid && s_axi_arready;
	assign mon_vec = mon;
	// Events are rising edges of each live condition
	assign evt_set = mon_vec & ~s_r.mon_prev;

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		s_nxt = s_r;
		s_nxt.mon_prev = mon_vec;
		if (!s_r.readback_off) begin
			s_nxt.status = mon_vec;
		end
		unique case (s_r.wst)
			ZDCPS_W_IDLE: begin
				if (aw_take) begin
					s_nxt.aw_got = 1'b1;
					s_nxt.waddr = s_axi_awaddr;
				end
				if (w_take) begin
					s_nxt.w_got = 1'b1;
					s_nxt.wdata = s_axi_wdata;
					s_nxt.wstrb = s_axi_wstrb;
				end
				if ((s_r.aw_got || aw_take) && (s_r.w_got || w_take)) begin
					s_nxt.wst = ZDCPS_W_HAVE;
				end
			end
			ZDCPS_W_HAVE: begin
				s_nxt.wst = ZDCPS_W_RESP;
				s_nxt.aw_got = 1'b0;
				s_nxt.w_got = 1'b0;
				s_nxt.bresp = addr_known(s_r.waddr) ? ZDCPS_RESP_OKAY : ZDCPS_RESP_SLVERR;
				if (s_r.wstrb[0]) begin
					unique case (s_r.waddr)
						ZDCPS_ADDR_ZD_CTRL: begin
							// Only the documented fields hold state; the rest read zero
							s_nxt.zd_ctrl = s_r.wdata[7:0] & ZDCPS_ZD_CTRL_MASK;
						end
						ZDCPS_ADDR_EVT_STAT: begin
							s_nxt.evt_stat = s_r.evt_stat & ~s_r.wdata[6:0];
						end
						ZDCPS_ADDR_EVT_MASK: s_nxt.evt_mask = s_r.wdata[6:0];
						ZDCPS_ADDR_READBACK_CTRL: s_nxt.readback_off = s_r.wdata[0];
						// Status is read only; the write is acknowledged and dropped
						ZDCPS_ADDR_STATUS: s_nxt.status = s_nxt.status;
						default: s_nxt.bresp = s_nxt.bresp;
					endcase
				end
			end
			ZDCPS_W_RESP: begin
				if (s_axi_bready) begin
					s_nxt.wst = ZDCPS_W_IDLE;
				end
			end
		endcase
		// Set wins over a same-cycle write-one clear
		s_nxt.evt_stat = s_nxt.evt_stat | evt_set;
		if (ar_take) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata = read_word(s_r, s_axi_araddr);
			s_nxt.rresp = addr_known(s_axi_araddr) ? ZDCPS_RESP_OKAY : ZDCPS_RESP_SLVERR;
		end else if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			s_r.wst <= ZDCPS_W_IDLE;
			s_r.aw_got <= 1'b0;
			s_r.w_got <= 1'b0;
			s_r.waddr <= '0;
			s_r.wdata <= 32'h0000_0000;
			s_r.wstrb <= 4'h0;
			s_r.bresp <= ZDCPS_RESP_OKAY;
			s_r.rvalid <= 1'b0;
			s_r.rdata <= 32'h0000_0000;
			s_r.rresp <= ZDCPS_RESP_OKAY;
			s_r.zd_ctrl <= ZDCPS_ZD_CTRL_RST;
			s_r.status <= ZDCPS_STATUS_RST;
			s_r.readback_off <= 1'b0;
			s_r.evt_stat <= ZDCPS_EVT_RST;
			s_r.evt_mask <= ZDCPS_EVT_RST;
			s_r.mon_prev <= ZDCPS_STATUS_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign s_axi_bvalid = s_r.wst == ZDCPS_W_RESP;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_rvalid = s_r.rvalid;
	assign s_axi_rdata = s_r.rdata;
	assign s_axi_rresp = s_r.rresp;
	assign irq = |(s_r.evt_stat & s_r.evt_mask);

	always_comb begin
		zd_cfg.zd_enable = s_r.zd_ctrl[ZDCPS_ZD_EN_BIT];
		// Mode only matters while enabled
		zd_cfg.zd_external = s_r.zd_ctrl[ZDCPS_ZD_EN_BIT] & s_r.zd_ctrl[ZDCPS_ZD_EXT_BIT];
		zd_cfg.fb_div_sel = s_r.zd_ctrl[ZDCPS_FB_SEL_LSB +: 2];
		zd_cfg.fb_div_onehot = 4'h0;
		unique case (zd_cfg.fb_div_sel)
			ZDCPS_FB_DIV0: zd_cfg.fb_div_onehot = 4'h1;
			ZDCPS_FB_DIV1: zd_cfg.fb_div_onehot = 4'h2;
			ZDCPS_FB_DIV2: zd_cfg.fb_div_onehot = 4'h4;
			ZDCPS_FB_DIV3: zd_cfg.fb_div_onehot = 4'h8;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	// Status path: one cycle behind the monitors while refresh is on

	status_tracks_a: assert property (!s_r.readback_off ##1 !$past(s_r.readback_off)
		|-> s_r.status == $past(mon_vec)) else $error("status not tracking monitors");

	status_frozen_a: assert property (s_r.readback_off |=> $stable(s_r.status))
		else $error("status changed while readback off");

	cal_bit_a: assert property (!s_r.readback_off
		|=> s_r.status[6] == $past(mon.cal_done)) else $error("calibration bit wrong");

	hold_bit_a: assert property (!s_r.readback_off
		|=> s_r.status[5] == $past(mon.holdover_active)) else $error("holdover bit wrong");

	ref_sel_a: assert property (!s_r.readback_off
		|=> s_r.status[4] == $past(mon.second_ref_sel)) else $error("reference select bit wrong");

	vco_bit_a: assert property (!s_r.readback_off
		|=> s_r.status[3] == $past(mon.vco_above)) else $error("vco threshold bit wrong");

	second_reference_input_thr_a: assert property (!s_r.readback_off
		|=> s_r.status[2] == $past(mon.second_ref_above)) else $error("second reference bit wrong");

	first_reference_input_thr_a: assert property (!s_r.readback_off
		|=> s_r.status[1] == $past(mon.first_ref_above)) else $error("first reference bit wrong");

	lock_bit_a: assert property (!s_r.readback_off
		|=> s_r.status[0] == $past(mon.locked)) else $error("lock bit wrong");

	ro_write_a: assert property (s_r.wst == ZDCPS_W_HAVE && s_r.waddr == ZDCPS_ADDR_STATUS
		&& s_r.readback_off |=> $stable(s_r.status)) else $error("status written");

	status_wr_on_a: assert property (s_r.wst == ZDCPS_W_HAVE
		&& s_r.waddr == ZDCPS_ADDR_STATUS && !s_r.readback_off
		|=> s_r.status == $past(mon_vec)) else $error("status write not ignored");

	status_read_a: assert property (s_axi_arvalid && s_axi_arready
		&& s_axi_araddr == ZDCPS_ADDR_STATUS |=> s_axi_rdata == {25'h0, $past(s_r.status)})
		else $error("status read data wrong");

	////////////////////////////////////////////////////////////////////////////////
	// Zero-delay configuration

	div_sel_a: assert property ($onehot(zd_cfg.fb_div_onehot)
		&& zd_cfg.fb_div_onehot[zd_cfg.fb_div_sel]) else $error("divider select decode wrong");

	mode_gate_a: assert property (zd_cfg.zd_external |-> zd_cfg.zd_enable)
		else $error("external mode without enable");

	en_write_a: assert property (s_r.wst == ZDCPS_W_HAVE && s_r.waddr == ZDCPS_ADDR_ZD_CTRL
		&& s_r.wstrb[0] |=> zd_cfg.zd_enable == $past(s_r.wdata[1]))
		else $error("enable bit not written");

	mode_write_a: assert property (s_r.wst == ZDCPS_W_HAVE && s_r.waddr == ZDCPS_ADDR_ZD_CTRL
		&& s_r.wstrb[0] |=> s_r.zd_ctrl[ZDCPS_ZD_EXT_BIT] == $past(s_r.wdata[2]))
		else $error("mode bit not written");

	sel_write_a: assert property (s_r.wst == ZDCPS_W_HAVE && s_r.waddr == ZDCPS_ADDR_ZD_CTRL
		&& s_r.wstrb[0] |=> zd_cfg.fb_div_sel == $past(s_r.wdata[4:3]))
		else $error("divider select not written");

	resv_zero_a: assert property ((s_r.zd_ctrl & ~ZDCPS_ZD_CTRL_MASK) == 8'h00)
		else $error("reserved control bits set");

	cfg_hold_a: assert property (s_r.wst != ZDCPS_W_HAVE |=> $stable(s_r.zd_ctrl))
		else $error("control changed without a write");

	strobe_gate_a: assert property (s_r.wst == ZDCPS_W_HAVE && !s_r.wstrb[0]
		|=> $stable(s_r.zd_ctrl) && $stable(s_r.evt_mask)) else $error("unstrobed write landed");

	bad_write_a: assert property (s_r.wst == ZDCPS_W_HAVE && !addr_known(s_r.waddr)
		|=> $stable(s_r.zd_ctrl) && $stable(s_r.evt_mask) && $stable(s_r.readback_off))
		else $error("unmapped write landed");

	////////////////////////////////////////////////////////////////////////////////
	// Bus handshakes

	bresp_time_a: assert property (s_r.wst == ZDCPS_W_HAVE |=> s_axi_bvalid)
		else $error("write response late");

	bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");

	b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");

	aw_busy_a: assert property (s_r.wst != ZDCPS_W_IDLE |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");

	bresp_err_a: assert property (s_r.wst == ZDCPS_W_HAVE && !addr_known(s_r.waddr)
		|=> s_axi_bresp == ZDCPS_RESP_SLVERR) else $error("unmapped write not refused");

	read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");

	rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read data dropped");

	r_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data repeated");

	ar_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");

	bad_read_a: assert property (s_axi_arvalid && s_axi_arready && !addr_known(s_axi_araddr)
		|=> s_axi_rresp == ZDCPS_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
		else $error("unmapped read not refused");

	////////////////////////////////////////////////////////////////////////////////
	// Events and interrupt

	irq_level_a: assert property (irq == |(s_r.evt_stat & s_r.evt_mask))
		else $error("interrupt level wrong");

	evt_capture_a: assert property (|evt_set |=> (s_r.evt_stat & $past(evt_set)) == $past(evt_set))
		else $error("event not captured");

	evt_clear_a: assert property (s_r.wst == ZDCPS_W_HAVE && s_r.waddr == ZDCPS_ADDR_EVT_STAT
		&& s_r.wstrb[0] |=> (s_r.evt_stat & $past(s_r.wdata[6:0]) & ~$past(evt_set)) == 7'h00)
		else $error("event not cleared");

	evt_sticky_a: assert property (s_r.wst != ZDCPS_W_HAVE
		|=> (s_r.evt_stat & $past(s_r.evt_stat)) == $past(s_r.evt_stat))
		else $error("event lost without a clear");

	mask_write_a: assert property (s_r.wst == ZDCPS_W_HAVE && s_r.waddr == ZDCPS_ADDR_EVT_MASK
		&& s_r.wstrb[0] |=> s_r.evt_mask == $past(s_r.wdata[6:0]))
		else $error("mask not written");

	rb_write_a: assert property (s_r.wst == ZDCPS_W_HAVE
		&& s_r.waddr == ZDCPS_ADDR_READBACK_CTRL && s_r.wstrb[0]
		|=> s_r.readback_off == $past(s_r.wdata[0])) else $error("readback control not written");

	// Covers for the main scenarios

	write_cv: cover property (s_r.wst == ZDCPS_W_HAVE && s_r.waddr == ZDCPS_ADDR_ZD_CTRL);
	read_cv: cover property (s_axi_rvalid && s_axi_rready);
	freeze_cv: cover property (s_r.readback_off && mon_vec != s_r.status);
	irq_cv: cover property (irq);
	bad_resp_cv: cover property (s_axi_bvalid && s_axi_bresp == ZDCPS_RESP_SLVERR);

endmodule // zdcps_regs

/* sim/zdcps_regs_tb_top.sv */
// Self-checking testbench for the zero-delay configuration and PLL status register bank
module zdcps_regs_tb_top
	import zdcps_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [1:0] OK = ZDCPS_RESP_OKAY;
	logic ref_clk, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [9:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	zdcps_mon_t mon;
	zdcps_zd_t zd_cfg;
	int miscompares = 0;
	int checks = 0;
	////////////////////////////////////////////////////////////////////////////////////////////
	zdcps_regs zdcps_regs_i (
		.ref_clk(ref_clk), .rstn(rstn),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.mon(mon), .zd_cfg(zd_cfg), .irq(irq)
	);
	initial begin
		ref_clk = 1'h0;
		forever #50 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	// Ready is sampled on the falling edge, where it has settled, and acted on at the next rise
	task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do begin
			@(negedge ref_clk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			@(posedge ref_clk);
			if (ta) s_axi_awvalid <= 1'h0;
			if (tw) s_axi_wvalid <= 1'h0;
		end while ((s_axi_awvalid & !ta) | (s_axi_wvalid & !tw));
		do @(negedge ref_clk); while (!s_axi_bvalid);
		chk(32'(s_axi_bresp), 32'(er));
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [9:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic t;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do begin
			@(negedge ref_clk);
			t = s_axi_arready;
			@(posedge ref_clk);
		end while (!t);
		s_axi_arvalid <= 1'h0;
		do @(negedge ref_clk); while (!s_axi_rvalid);
		chk(s_axi_rdata, ed);
		chk(32'(s_axi_rresp), 32'(er));
		@(posedge ref_clk);
	endtask
	task automatic chk_irq(input logic e);
		@(negedge ref_clk);
		chk({31'h0, irq}, {31'h0, e});
		@(posedge ref_clk);
	endtask
	////////////////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd(ZDCPS_ADDR_ZD_CTRL, 32'h0, OK);
		chk({24'h0, zd_cfg}, 32'h01);
		chk_irq(1'h0);
	endtask
	task automatic t_zd();
		zdcps_zd_t e;
		for (int i = 0; i < 16; i++) begin
			wr(ZDCPS_ADDR_ZD_CTRL, 32'(i << 1), OK);
			e.zd_enable = i[0];
			e.zd_external = i[0] & i[1];
			e.fb_div_sel = i[3:2];
			e.fb_div_onehot = 4'h1 << i[3:2];
			chk({24'h0, zd_cfg}, {24'h0, e});
			rd(ZDCPS_ADDR_ZD_CTRL, 32'(i << 1), OK);
		end
		wr(ZDCPS_ADDR_ZD_CTRL, 32'hff, OK);
		rd(ZDCPS_ADDR_ZD_CTRL, 32'h1e, OK);
		// Without lane 0 the write is answered but lands nowhere
		s_axi_wstrb <= 4'he;
		wr(ZDCPS_ADDR_ZD_CTRL, 32'h0, OK);
		s_axi_wstrb <= 4'hf;
		rd(ZDCPS_ADDR_ZD_CTRL, 32'h1e, OK);
	endtask
	task automatic t_status();
		for (int b = 0; b < 7; b++) begin
			mon <= zdcps_mon_t'(7'h1 << b);
			repeat (2) @(posedge ref_clk);
			rd(ZDCPS_ADDR_STATUS, 32'h1 << b, OK);
		end
	endtask
	task automatic t_freeze();
		wr(ZDCPS_ADDR_READBACK_CTRL, 32'h1, OK);
		mon <= 7'h7f;
		repeat (2) @(posedge ref_clk);
		rd(ZDCPS_ADDR_STATUS, 32'h40, OK);
		wr(ZDCPS_ADDR_STATUS, 32'hff, OK);
		rd(ZDCPS_ADDR_STATUS, 32'h40, OK);
		wr(ZDCPS_ADDR_READBACK_CTRL, 32'h0, OK);
		repeat (2) @(posedge ref_clk);
		rd(ZDCPS_ADDR_STATUS, 32'h7f, OK);
		wr(ZDCPS_ADDR_STATUS, 32'h0, OK);
		rd(ZDCPS_ADDR_STATUS, 32'h7f, OK);
		wr(10'h3fc, 32'h1, ZDCPS_RESP_SLVERR);
		rd(10'h3fc, 32'h0, ZDCPS_RESP_SLVERR);
	endtask
	task automatic t_irq();
		mon <= 7'h00;
		repeat (2) @(posedge ref_clk);
		// Earlier scenarios left sticky events behind
		wr(ZDCPS_ADDR_EVT_STAT, 32'h7f, OK);
		wr(ZDCPS_ADDR_EVT_MASK, 32'h1, OK);
		chk_irq(1'h0);
		mon <= 7'h01;
		repeat (3) @(posedge ref_clk);
		chk_irq(1'h1);
		rd(ZDCPS_ADDR_EVT_STAT, 32'h1, OK);
		wr(ZDCPS_ADDR_EVT_MASK, 32'h0, OK);
		chk_irq(1'h0);
		wr(ZDCPS_ADDR_EVT_MASK, 32'h1, OK);
		chk_irq(1'h1);
		wr(ZDCPS_ADDR_EVT_STAT, 32'h1, OK);
		chk_irq(1'h0);
		rd(ZDCPS_ADDR_EVT_STAT, 32'h0, OK);
	endtask
	////////////////////////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		$display("unexpected at %0t: run did not finish", $time);
		summarize();
	end
	initial begin
		rstn = 1'h0;
		s_axi_awvalid = 1'h0;
		s_axi_wvalid = 1'h0;
		s_axi_arvalid = 1'h0;
		s_axi_awaddr = 10'h0;
		s_axi_araddr = 10'h0;
		s_axi_wdata = 32'h0;
		// Response readies stay fixed; only byte lane 0 of the strobe matters
		s_axi_wstrb = 4'hf;
		s_axi_bready = 1'h1;
		s_axi_rready = 1'h1;
		mon = 7'h00;
		repeat (6) @(posedge ref_clk);
		rstn <= 1'h1;
		@(posedge ref_clk);
		t_reset();
		t_zd();
		t_status();
		t_freeze();
		t_irq();
		summarize();
	end
endmodule // zdcps_regs_tb_top
